// ===== verilog/ellj_pkg.sv
// Constants, register map and types of the event linked level judge.
// Assumes an APB master on MCLK and a converter that presents its results.
//
// Function
// R1: Chain enable set makes the next descriptor run right after the current.
// R2: One activation: store ch0, store ch1, load threshold, load ch0 input.
// R3: All descriptors but the last chain; the last does not.
// R4: Each descriptor moves 2-byte units, repeat mode, fixed source.
// R5: Buffer descriptors increment destination and wrap at buffer length.
// R6: Operation unit descriptors use fixed destination, one unit per run.
// R7: Operation unit compares, adds or subtracts 16-bit data, irq on hit.
// R8: Subtract mode: input minus setting, flag set when result negative.
// R9: Link unit routes event to each destination holding its source code.
// R10: No event link acts until the global link enable is written 1.
// R11: Software picks snooze or timer event as converter start source.
// R12: Operation irq drives port group 1, window match drives group 2.
// R13: Ports 1 and 2 each respond to their own port group event.
// R14: On group event, pins with set enable 1 go to 1, others kept (here a pin with reset enable 1 goes to 0).
// R15: On group event, pins with reset enable 1 go to 0, others kept.
// R16: Transfer starts only when the trigger enable bit is 1.
// R17: After a full repeat size the repeat address returns to start.
// R18: Converter result auto-clear stays off so ch0 is read twice.
// R19: Each descriptor writes before the next reads.
// R20: Result flag stays until cleared; each new negative gives one event.
package ellj_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00; // trigger en, link en
    localparam logic [7:0] OFS_OPCTL  = 8'h04; // mode, flag
    localparam logic [7:0] OFS_SET    = 8'h08; // setting value
    localparam logic [7:0] OFS_INP    = 8'h0C; // input value
    localparam logic [7:0] OFS_THR    = 8'h10; // threshold variable
    localparam logic [7:0] OFS_LSEL1  = 8'h14; // link select port 1
    localparam logic [7:0] OFS_LSEL2  = 8'h18; // link select port 2
    localparam logic [7:0] OFS_PORT1  = 8'h1C; // set en, reset en, value
    localparam logic [7:0] OFS_PORT2  = 8'h20;
    localparam logic [7:0] OFS_BUFLEN = 8'h24; // buffer length
    localparam logic [7:0] OFS_BIDX   = 8'h28; // buffer indices
    localparam logic [7:0] OFS_BUF0   = 8'h40; // ch0 buffer window
    localparam logic [7:0] OFS_BUF1   = 8'h80; // ch1 buffer window

    // ****************************************************************
    // Sizes and codes
    // ****************************************************************
    localparam int BUF_DEPTH = 16;
    localparam int BUF_AW    = 4;
    localparam int PIN_W     = 8;
    localparam logic [7:0] EVT_OP_IRQ  = 8'h01; // arbitrary source codes
    localparam logic [7:0] EVT_WMATCH  = 8'h02;
    localparam logic [1:0] MODE_CMP    = 2'h0;
    localparam logic [1:0] MODE_ADD    = 2'h1;
    localparam logic [1:0] MODE_SUB    = 2'h2;
    localparam logic [4:0] DESC_LAST   = 5'h1_0;
    localparam logic [4:0] CHAIN_MASK  = 5'h0_7; // descriptors 0..2 chain

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'b0_0001,
        ST_D0   = 5'b0_0010,
        ST_D1   = 5'b0_0100,
        ST_D2   = 5'b0_1000,
        ST_D3   = 5'b1_0000
    } ellj_state_e;

    typedef struct packed {
        ellj_state_e                st;
        logic                       trig_en;
        logic                       link_en;
        logic [1:0]                 mode;
        logic                       flag;
        logic                       op_evt;
        logic                       neg_prev;
        logic [15:0]                set_v;
        logic [15:0]                inp_v;
        logic [15:0]                thr;
        logic [7:0]                 lsel1;
        logic [7:0]                 lsel2;
        logic [PIN_W-1:0]           sen1;
        logic [PIN_W-1:0]           ren1;
        logic [PIN_W-1:0]           pout1;
        logic [PIN_W-1:0]           sen2;
        logic [PIN_W-1:0]           ren2;
        logic [PIN_W-1:0]           pout2;
        logic [BUF_AW-1:0]          blen;
        logic [BUF_AW-1:0]          idx0;
        logic [BUF_AW-1:0]          idx1;
        logic [BUF_DEPTH-1:0][15:0] buf0;
        logic [BUF_DEPTH-1:0][15:0] buf1;
        logic [1:0]                 trg_s;
        logic [1:0]                 wm_s;
        logic                       trg_d;
        logic                       wm_d;
        logic [31:0]                prdata;
        logic                       pready;
        logic                       pslverr;
    } ellj_state_s;

endpackage

// ===== verilog/ellj_top.sv
// Level judge: chained transfer, operation unit, event link, port groups.
// Assumes converter results are stable while a start pulse is taken.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
module ellj_top (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_B,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Converter side
    input  wire logic        CONV_DONE,
    input  wire logic [15:0] CONV_CH0,
    input  wire logic [15:0] CONV_CH1,
    input  wire logic        CONV_WMATCH,
    // Port pins
    output logic      [7:0]  PORT1_OUT,
    output logic      [7:0]  PORT2_OUT,
    output logic             OP_IRQ
);

    ellj_pkg::ellj_state_s s_r;
    ellj_pkg::ellj_state_s s_nxt;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic        wr;
        logic        rd;
        logic [16:0] diff;
        logic        neg;
        logic        hit;
        logic        trg_p;
        logic        wm_p;
        logic        ev1;
        logic        ev2;
        logic        clr_flag;
        s_nxt = s_r;
        wr = PSEL && PENABLE && PWRITE;
        rd = PSEL && PENABLE && !PWRITE;
        clr_flag = 1'b0;
        diff = '0;
        neg = 1'b0;
        hit = 1'b0;
        trg_p = 1'b0;
        wm_p = 1'b0;
        ev1 = 1'b0;
        ev2 = 1'b0;
        // One wait state: answer the edge after the access phase is seen
        s_nxt.pready = PSEL && PENABLE && !s_r.pready;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata = '0;
        s_nxt.op_evt = 1'b0;
        // Pin inputs through two flops
        s_nxt.trg_s = {s_r.trg_s[0], CONV_DONE};
        s_nxt.wm_s = {s_r.wm_s[0], CONV_WMATCH};
        s_nxt.trg_d = s_r.trg_s[1];
        s_nxt.wm_d = s_r.wm_s[1];
        trg_p = s_r.trg_s[1] && !s_r.trg_d;
        wm_p = s_r.wm_s[1] && !s_r.wm_d;

        // Chained transfer sequence
        case (s_r.st)
            ellj_pkg::ST_IDLE: begin
                if (trg_p && s_r.trig_en) begin // [R16]
                    s_nxt.st = ellj_pkg::ST_D0;
                end
            end
            ellj_pkg::ST_D0: begin // [R2] [R4] [R5] [R17]
                s_nxt.buf0[s_r.idx0] = CONV_CH0;
                s_nxt.idx0 = (s_r.idx0 == s_r.blen) ? '0 : s_r.idx0 + 1'b1;
                s_nxt.st = ellj_pkg::CHAIN_MASK[0] ? ellj_pkg::ST_D1
                                                   : ellj_pkg::ST_IDLE; // [R1]
            end
            ellj_pkg::ST_D1: begin // [R2] [R5] [R17]
                s_nxt.buf1[s_r.idx1] = CONV_CH1;
                s_nxt.idx1 = (s_r.idx1 == s_r.blen) ? '0 : s_r.idx1 + 1'b1;
                s_nxt.st = ellj_pkg::CHAIN_MASK[1] ? ellj_pkg::ST_D2
                                                   : ellj_pkg::ST_IDLE; // [R1]
            end
            ellj_pkg::ST_D2: begin // [R6] [R19]
                s_nxt.set_v = s_r.thr;
                s_nxt.st = ellj_pkg::CHAIN_MASK[2] ? ellj_pkg::ST_D3
                                                   : ellj_pkg::ST_IDLE; // [R3]
            end
            ellj_pkg::ST_D3: begin // [R6] [R19]
                s_nxt.inp_v = CONV_CH0;
                s_nxt.st = ellj_pkg::ST_IDLE; // [R3]
            end
            default: s_nxt.st = ellj_pkg::ST_IDLE;
        endcase

        // Register access
        if (wr && !s_r.pready) begin
            if (PADDR == ellj_pkg::OFS_CTRL) begin
                s_nxt.trig_en = PWDATA[0];
                s_nxt.link_en = PWDATA[1]; // [R10]
            end else if (PADDR == ellj_pkg::OFS_OPCTL) begin
                s_nxt.mode = PWDATA[1:0];
                clr_flag = PWDATA[8];
            end else if (PADDR == ellj_pkg::OFS_SET) begin
                s_nxt.set_v = PWDATA[15:0];
            end else if (PADDR == ellj_pkg::OFS_INP) begin
                s_nxt.inp_v = PWDATA[15:0];
            end else if (PADDR == ellj_pkg::OFS_THR) begin
                s_nxt.thr = PWDATA[15:0];
            end else if (PADDR == ellj_pkg::OFS_LSEL1) begin
                s_nxt.lsel1 = PWDATA[7:0];
            end else if (PADDR == ellj_pkg::OFS_LSEL2) begin
                s_nxt.lsel2 = PWDATA[7:0];
            end else if (PADDR == ellj_pkg::OFS_PORT1) begin
                s_nxt.sen1 = PWDATA[7:0];
                s_nxt.ren1 = PWDATA[15:8];
                s_nxt.pout1 = PWDATA[23:16];
            end else if (PADDR == ellj_pkg::OFS_PORT2) begin
                s_nxt.sen2 = PWDATA[7:0];
                s_nxt.ren2 = PWDATA[15:8];
                s_nxt.pout2 = PWDATA[23:16];
            end else if (PADDR == ellj_pkg::OFS_BUFLEN) begin
                s_nxt.blen = PWDATA[ellj_pkg::BUF_AW-1:0];
            end else if (PADDR == ellj_pkg::OFS_BIDX) begin
                s_nxt.idx0 = '0;
                s_nxt.idx1 = '0;
            end else begin
                s_nxt.pslverr = PADDR < ellj_pkg::OFS_BUF0;
            end
        end else if (rd && !s_r.pready) begin
            if (PADDR == ellj_pkg::OFS_CTRL) begin
                s_nxt.prdata = {30'h0, s_r.link_en, s_r.trig_en};
            end else if (PADDR == ellj_pkg::OFS_OPCTL) begin
                s_nxt.prdata = {23'h0, s_r.flag, 6'h0, s_r.mode};
            end else if (PADDR == ellj_pkg::OFS_SET) begin
                s_nxt.prdata = {16'h0, s_r.set_v};
            end else if (PADDR == ellj_pkg::OFS_INP) begin
                s_nxt.prdata = {16'h0, s_r.inp_v};
            end else if (PADDR == ellj_pkg::OFS_THR) begin
                s_nxt.prdata = {16'h0, s_r.thr};
            end else if (PADDR == ellj_pkg::OFS_LSEL1) begin
                s_nxt.prdata = {24'h0, s_r.lsel1};
            end else if (PADDR == ellj_pkg::OFS_LSEL2) begin
                s_nxt.prdata = {24'h0, s_r.lsel2};
            end else if (PADDR == ellj_pkg::OFS_PORT1) begin
                s_nxt.prdata = {8'h0, s_r.pout1, s_r.ren1, s_r.sen1};
            end else if (PADDR == ellj_pkg::OFS_PORT2) begin
                s_nxt.prdata = {8'h0, s_r.pout2, s_r.ren2, s_r.sen2};
            end else if (PADDR == ellj_pkg::OFS_BUFLEN) begin
                s_nxt.prdata = {28'h0, s_r.blen};
            end else if (PADDR == ellj_pkg::OFS_BIDX) begin
                s_nxt.prdata = {24'h0, s_r.idx1, s_r.idx0};
            end else if (PADDR >= ellj_pkg::OFS_BUF1) begin
                s_nxt.prdata = {16'h0, s_r.buf1[PADDR[5:2]]};
            end else if (PADDR >= ellj_pkg::OFS_BUF0) begin
                s_nxt.prdata = {16'h0, s_r.buf0[PADDR[5:2]]};
            end else begin
                s_nxt.pslverr = 1'b1;
            end
        end

        // Operation unit
        diff = {1'b0, s_r.inp_v} - {1'b0, s_r.set_v}; // [R8]
        case (s_r.mode)
            ellj_pkg::MODE_CMP: hit = (s_r.inp_v == s_r.set_v); // [R7]
            ellj_pkg::MODE_ADD: hit = diff[16] ^ diff[16]
                                 | ({1'b0, s_r.inp_v} + {1'b0, s_r.set_v})
                                   > 17'h0_FFFF; // [R7]
            ellj_pkg::MODE_SUB: hit = diff[16]; // [R8]
            default:            hit = 1'b0;
        endcase
        neg = hit;
        if (neg && !s_r.neg_prev) begin
            s_nxt.op_evt = 1'b1; // [R20]
        end
        s_nxt.neg_prev = neg;
        if (neg) begin
            s_nxt.flag = 1'b1; // [R20]
        end else if (clr_flag) begin
            s_nxt.flag = 1'b0;
        end

        // Event link and port groups
        ev1 = s_r.link_en && ((s_r.lsel1 == ellj_pkg::EVT_OP_IRQ && s_r.op_evt)
              || (s_r.lsel1 == ellj_pkg::EVT_WMATCH && wm_p)); // [R9] [R10]
        ev2 = s_r.link_en && ((s_r.lsel2 == ellj_pkg::EVT_OP_IRQ && s_r.op_evt)
              || (s_r.lsel2 == ellj_pkg::EVT_WMATCH && wm_p)); // [R12]
        if (ev1) begin // [R13]
            s_nxt.pout1 = (s_nxt.pout1 | s_r.sen1) & ~s_r.ren1; // [R14] [R15]
        end
        if (ev2) begin // [R13]
            s_nxt.pout2 = (s_nxt.pout2 | s_r.sen2) & ~s_r.ren2; // [R14] [R15]
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            s_r <= '0;
            s_r.st <= ellj_pkg::ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign PRDATA    = s_r.prdata;
    assign PREADY    = s_r.pready;
    assign PSLVERR   = s_r.pslverr;
    assign PORT1_OUT = s_r.pout1;
    assign PORT2_OUT = s_r.pout2;
    assign OP_IRQ    = s_r.op_evt;

endmodule // ellj_top

// ===== tb/ellj_chk.sv
// Port checker for the level judge top.
// Assumes a bind onto ellj_top, one clock MCLK.
`timescale 1ns/1ps
module ellj_chk (
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RST_B,
    // APB
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Converter and pins
    input wire logic        CONV_DONE,
    input wire logic [15:0] CONV_CH0,
    input wire logic [15:0] CONV_CH1,
    input wire logic        CONV_WMATCH,
    input wire logic [7:0]  PORT1_OUT,
    input wire logic [7:0]  PORT2_OUT,
    input wire logic        OP_IRQ
);
    // ****
    // Event age counters
    // ****
    logic [2:0] op_age_r;
    logic [2:0] wm_age_r;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            op_age_r <= 3'h7;
            wm_age_r <= 3'h7;
        end else begin
            op_age_r <= OP_IRQ ? 3'h0 : op_age_r + 3'(op_age_r != 3'h7);
            wm_age_r <= CONV_WMATCH ? 3'h0
                      : wm_age_r + 3'(wm_age_r != 3'h7);
        end
    end
    property p_ready_ans; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
    a_ready_ans: assert property (p_ready_ans) else $error("no answer");
    property p_ready_one; PREADY |=> !PREADY; endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready held");
    property p_ready_src; PREADY |-> $past(PSEL && PENABLE); endproperty
    a_ready_src: assert property (p_ready_src) else $error("stray ready");
    property p_err; PSLVERR |-> PREADY; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_irq_one; OP_IRQ |=> !OP_IRQ; endproperty
    a_irq_one: assert property (p_irq_one) else $error("irq held");
    property p_p1;
        !$stable(PORT1_OUT) |-> op_age_r != 3'h7 || (PREADY && PWRITE);
    endproperty
    a_p1: assert property (p_p1) else $error("port1 moved");
    property p_p2;
        !$stable(PORT2_OUT) |-> wm_age_r != 3'h7 || (PREADY && PWRITE);
    endproperty
    a_p2: assert property (p_p2) else $error("port2 moved");
    property p_rst;
        $rose(RST_B) |-> PORT1_OUT == 8'h00 && PORT2_OUT == 8'h00 && !OP_IRQ;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
endmodule // ellj_chk

bind ellj_top ellj_chk ellj_chk_inst (
    .MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CONV_DONE(CONV_DONE),
    .CONV_CH0(CONV_CH0), .CONV_CH1(CONV_CH1), .CONV_WMATCH(CONV_WMATCH),
    .PORT1_OUT(PORT1_OUT), .PORT2_OUT(PORT2_OUT), .OP_IRQ(OP_IRQ)
);

// ===== tb/ellj_conv_model.sv
// Converter model: start pulse, held results, window match.
// Assumes requests come at least 12 cycles apart.
`timescale 1ns/1ps
module ellj_conv_model (
    // Clock and requests
    input wire logic        MCLK,
    input wire logic        req,
    input wire logic        dn,
    input wire logic        wm,
    input wire logic [15:0] d0,
    input wire logic [15:0] d1,
    // Converter outputs
    output logic            CONV_DONE,
    output logic            CONV_WMATCH,
    output logic     [15:0] CONV_CH0,
    output logic     [15:0] CONV_CH1
);
    logic [3:0] cnt_r = 4'h0;
    initial begin
        CONV_DONE = 1'b0;
        CONV_WMATCH = 1'b0;
        CONV_CH0 = 16'h0000;
        CONV_CH1 = 16'h0000;
    end
    // Start source is the bench request
    always @(posedge MCLK) begin
        if (req) begin
            cnt_r <= 4'hA;
            CONV_DONE <= dn;
            CONV_WMATCH <= wm;
            if (dn) begin
                CONV_CH0 <= d0; // Results held, never cleared
                CONV_CH1 <= d1;
            end
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end else begin
            CONV_DONE <= 1'b0;
            CONV_WMATCH <= 1'b0;
        end
    end
endmodule // ellj_conv_model

// ===== tb/ellj_top_tb.sv
// Bench for the level judge: APB master, converter model, checks.
// Assumes ellj_top, ellj_pkg and the converter model are compiled.
`timescale 1ns/1ps
module ellj_top_tb;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic        e;
    } ellj_row_s;
    logic        MCLK = 1'b0;
    logic        RST_B = 1'b0;
    logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic [31:0] PRDATA, rdat;
    logic        PREADY, PSLVERR, CONV_DONE, CONV_WMATCH, OP_IRQ, rerr;
    logic [15:0] CONV_CH0, CONV_CH1;
    logic [7:0]  PORT1_OUT, PORT2_OUT;
    logic        req = 1'b0, dn = 1'b0, wm = 1'b0;
    logic [15:0] d0 = 16'h0000, d1 = 16'h0000;
    int          miscompares = 0, n_tests = 0, n_irq = 0;
    ellj_row_s   rows [8] = '{
        '{ellj_pkg::OFS_CTRL, 32'h0000_0003, 1'b0},
        '{ellj_pkg::OFS_SET, 32'h0000_0001, 1'b0},
        '{ellj_pkg::OFS_INP, 32'h0000_7000, 1'b0},
        '{ellj_pkg::OFS_THR, 32'h0000_0100, 1'b0},
        '{ellj_pkg::OFS_LSEL1, 32'h0000_0001, 1'b0},
        '{ellj_pkg::OFS_LSEL2, 32'h0000_0002, 1'b0},
        '{ellj_pkg::OFS_BUFLEN, 32'h0000_0001, 1'b0},
        '{8'h2C, 32'h0000_0005, 1'b1}};
    ellj_top ellj_top_inst (.MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .CONV_DONE(CONV_DONE), .CONV_CH0(CONV_CH0), .CONV_CH1(CONV_CH1),
        .CONV_WMATCH(CONV_WMATCH), .PORT1_OUT(PORT1_OUT),
        .PORT2_OUT(PORT2_OUT), .OP_IRQ(OP_IRQ));
    ellj_conv_model ellj_conv_model_inst (.MCLK(MCLK), .req(req), .dn(dn),
        .wm(wm), .d0(d0), .d1(d1), .CONV_DONE(CONV_DONE),
        .CONV_WMATCH(CONV_WMATCH), .CONV_CH0(CONV_CH0), .CONV_CH1(CONV_CH1));
    always #5 MCLK = ~MCLK;
    always @(posedge MCLK) if (OP_IRQ === 1'b1) n_irq <= n_irq + 1;
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge MCLK);
            k++;
        end while (PREADY !== 1'b1 && k < 20);
        if (k >= 20) miscompares++;
        rdat = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, e);
    endtask
    task automatic act(input logic n, input logic m, input logic [15:0] x,
                       input logic [15:0] y);
        @(posedge MCLK);
        req <= 1'b1;
        dn <= n;
        wm <= m;
        d0 <= x;
        d1 <= y;
        @(posedge MCLK);
        req <= 1'b0;
        repeat (30) @(posedge MCLK);
    endtask
    task automatic end_of_test();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge MCLK);
        RST_B <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, rows[i].a, 32'h0000_0000);
            chk({31'h0000_0000, rerr}, {31'h0000_0000, rows[i].e});
            if (!rows[i].e) chk(rdat, 32'h0000_0000);
            wr(rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0000_0000);
            if (!rows[i].e) chk(rdat, rows[i].d);
        end
        $display("test rows done");
        wr(ellj_pkg::OFS_PORT1, 32'h00F0_F00F);
        wr(ellj_pkg::OFS_OPCTL, 32'h0000_0002);
        n_irq = 0;
        act(1'b1, 1'b0, 16'h0080, 16'h0111);
        rd(ellj_pkg::OFS_SET, 32'h0000_0100);
        rd(ellj_pkg::OFS_INP, 32'h0000_0080);
        rd(ellj_pkg::OFS_BUF0, 32'h0000_0080);
        rd(ellj_pkg::OFS_BUF1, 32'h0000_0111);
        rd(ellj_pkg::OFS_BIDX, 32'h0000_0011);
        chk({24'h00_0000, PORT1_OUT}, 32'h0000_000F);
        act(1'b1, 1'b0, 16'h0200, 16'h0222);
        rd(ellj_pkg::OFS_BIDX, 32'h0000_0000);
        rd(ellj_pkg::OFS_OPCTL, 32'h0000_0102);
        wr(ellj_pkg::OFS_OPCTL, 32'h0000_0102);
        rd(ellj_pkg::OFS_OPCTL, 32'h0000_0002);
        act(1'b1, 1'b0, 16'h0050, 16'h0333);
        rd(ellj_pkg::OFS_BUF0, 32'h0000_0050);
        rd(ellj_pkg::OFS_BUF0 + 8'h04, 32'h0000_0200);
        chk(n_irq, 2);
        wr(ellj_pkg::OFS_OPCTL, 32'h0000_0000);
        wr(ellj_pkg::OFS_INP, 32'h0000_0100);
        wr(ellj_pkg::OFS_OPCTL, 32'h0000_0001);
        wr(ellj_pkg::OFS_SET, 32'h0000_FF00);
        repeat (4) @(posedge MCLK);
        chk(n_irq, 4);
        $display("test chain done");
        wr(ellj_pkg::OFS_CTRL, 32'h0000_0002);
        act(1'b1, 1'b0, 16'h0333, 16'h0000);
        rd(ellj_pkg::OFS_INP, 32'h0000_0100);
        wr(ellj_pkg::OFS_CTRL, 32'h0000_0001);
        wr(ellj_pkg::OFS_PORT2, 32'h00AA_8085);
        act(1'b0, 1'b1, 16'h0000, 16'h0000);
        chk({24'h00_0000, PORT2_OUT}, 32'h0000_00AA);
        wr(ellj_pkg::OFS_CTRL, 32'h0000_0003);
        act(1'b0, 1'b1, 16'h0000, 16'h0000);
        chk({24'h00_0000, PORT2_OUT}, 32'h0000_002F);
        chk({24'h00_0000, PORT1_OUT}, 32'h0000_000F);
        $display("test link done");
        end_of_test();
    end
endmodule // ellj_top_tb
